// >>> verilog/rac_pkg.sv
// Constants shared by the alarm value and calibration block
package rac_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port geometry
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned NUM_ALARM = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_ALARM_MONTH_DAY = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_ALARM_WEEKDAY_HOURS = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_ALARM_MINUTES_SECONDS = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_CONFIG_CAL = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_TIMER_STATUS = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Implemented-bit masks, unused positions read zero
  localparam logic [DATA_W-1:0] MASK_MONTH_DAY = 16'h1f3f;
  localparam logic [DATA_W-1:0] MASK_WEEKDAY_HOURS = 16'h073f;
  localparam logic [DATA_W-1:0] MASK_MINUTES_SECONDS = 16'h7f7f;
  localparam logic [DATA_W-1:0] MASK_CONFIG = 16'ha0ff;
  localparam logic [DATA_W-1:0] MASK_STATUS = 16'h803f;

  // Alarm register set, indexed 0..2
  localparam logic [ADDR_W-1:0] ALARM_OFF [NUM_ALARM] = '{3'h0, 3'h1, 3'h2};
  localparam logic [DATA_W-1:0] ALARM_MASK [NUM_ALARM] = '{16'h1f3f, 16'h073f, 16'h7f7f};
  localparam logic ALARM_LOCKED [NUM_ALARM] = '{1'b1, 1'b1, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned MONTH_TENS_POS = 12;
  localparam int unsigned MONTH_ONES_LSB = 8;
  localparam int unsigned DAY_TENS_LSB = 4;
  localparam int unsigned DAY_ONES_LSB = 0;
  localparam int unsigned WEEKDAY_LSB = 8;
  localparam int unsigned HOUR_TENS_LSB = 4;
  localparam int unsigned HOUR_ONES_LSB = 0;
  localparam int unsigned MIN_TENS_LSB = 12;
  localparam int unsigned MIN_ONES_LSB = 8;
  localparam int unsigned SEC_TENS_LSB = 4;
  localparam int unsigned SEC_ONES_LSB = 0;
  localparam int unsigned CAL_LSB = 0;
  localparam int unsigned CAL_W = 8;
  localparam int unsigned CFG_WREN_POS = 13;
  localparam int unsigned CFG_TIMER_ON_POS = 15;
  localparam int unsigned STAT_SEC_LSB = 0;
  localparam int unsigned STAT_RUN_POS = 15;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [DATA_W-1:0] RST_ALARM = 16'h0000;
  localparam logic [DATA_W-1:0] RST_CONFIG = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Time base
  localparam int unsigned XTAL_HZ = 32768;
  localparam int unsigned SECONDS_PER_MIN = 60;
  localparam int unsigned SEC_CNT_W = 6;
  localparam int unsigned CAL_STEP = 4;
  localparam int unsigned CAL_SHIFT = $clog2(CAL_STEP);
  localparam int unsigned PRESC_W = 17;

endpackage : rac_pkg

// >>> verilog/rac_timebase.sv
// Crystal tick prescaler with per-minute drift correction
`timescale 1ns/100ps
module rac_timebase #(
  parameter int unsigned XTAL_HZ = rac_pkg::XTAL_HZ
) (
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Crystal pulse pin
  input wire logic i_xtal_pin,
  // Control
  input wire logic i_timer_on,
  input wire logic [rac_pkg::CAL_W-1:0] i_cal,
  // Time base outputs
  output logic o_second_pulse,
  output logic o_minute_pulse,
  output logic [rac_pkg::SEC_CNT_W-1:0] o_sec_count
);

  localparam int unsigned PW = rac_pkg::PRESC_W;
  localparam logic signed [PW-1:0] TERM = PW'(XTAL_HZ - 1);
  localparam logic [rac_pkg::SEC_CNT_W-1:0] SEC_LAST = rac_pkg::SEC_CNT_W'(rac_pkg::SECONDS_PER_MIN - 1);

  // Offset range is -512..+508, counter must hold it below the terminal count
  if (XTAL_HZ < 2 || XTAL_HZ > (2 ** (PW - 1)) - 1024) begin : g_bad_xtal
    $error("XTAL_HZ out of range for the prescaler");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser, third stage for edge detection only
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic signed [PW-1:0] presc_q;
  logic [rac_pkg::SEC_CNT_W-1:0] sec_q;

  wire logic tick = sync2_q & ~sync3_q & i_timer_on;
  wire logic sec_wrap = tick && (presc_q >= TERM);
  wire logic min_wrap = sec_wrap && (sec_q == SEC_LAST);
  wire logic signed [PW-1:0] cal_ext = {{(PW - rac_pkg::CAL_W){i_cal[rac_pkg::CAL_W-1]}}, i_cal};
  // Four pulses per unit; negative start delays rollover, positive hastens it
  wire logic signed [PW-1:0] cal_offset = cal_ext <<< rac_pkg::CAL_SHIFT;
  wire logic signed [PW-1:0] presc_d = sec_wrap ? (min_wrap ? cal_offset : '0) : PW'(presc_q + 1'b1);
  wire logic [rac_pkg::SEC_CNT_W-1:0] sec_d = min_wrap ? '0 : rac_pkg::SEC_CNT_W'(sec_q + 1'b1);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else if (i_ce) begin
      sync1_q <= i_xtal_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and seconds count, adjusted once per minute
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      presc_q <= '0;
      sec_q <= '0;
    end else if (i_ce && tick) begin
      presc_q <= presc_d;
      if (sec_wrap) begin
        sec_q <= sec_d;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_second_pulse <= 1'b0;
      o_minute_pulse <= 1'b0;
    end else if (i_ce) begin
      o_second_pulse <= sec_wrap;
      o_minute_pulse <= min_wrap;
    end
  end

  assign o_sec_count = sec_q;

endmodule : rac_timebase

// >>> verilog/rac_alarm_cal.sv
// Alarm value registers and drift calibration of the clock calendar unit
// Function
// - Weekday code in bits 10-8, 0..6
// - Hour BCD: tens bits 5-4, ones 3-0
// - Minute BCD in upper byte
// - Second BCD in lower byte
// - Unused alarm bits ignore writes, read zero
// - Month/day, weekday/hours writes need write enable
// - Signed calibration byte, times four, per minute
// - Negative value subtracts pulses each minute
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/100ps
module rac_alarm_cal #(
  parameter int unsigned XTAL_HZ = rac_pkg::XTAL_HZ
) (
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Register port
  input wire logic [rac_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rac_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [rac_pkg::DATA_W-1:0] o_rdata,
  // Crystal pulse pin
  input wire logic i_xtal_pin,
  // Alarm month and day
  output logic o_month_tens_digit,
  output logic [3:0] o_month_ones_digit,
  output logic [1:0] o_day_tens_digit,
  output logic [3:0] o_day_ones_digit,
  // Alarm weekday and hours
  output logic [2:0] o_weekday_code,
  output logic [1:0] o_hour_tens_digit,
  output logic [3:0] o_hour_ones_digit,
  // Alarm minutes and seconds
  output logic [2:0] o_minute_tens_digit,
  output logic [3:0] o_minute_ones_digit,
  output logic [2:0] o_second_tens_digit,
  output logic [3:0] o_second_ones_digit,
  // Time base
  output logic o_clock_write_enable,
  output logic o_second_pulse,
  output logic o_minute_pulse
);

  localparam int unsigned DW = rac_pkg::DATA_W;
  localparam int unsigned NA = rac_pkg::NUM_ALARM;

  if (DW != 16 || NA != 3) begin : g_bad_geometry
    $error("Register layout expects three 16-bit alarm registers");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helpers

  // Implemented bits of a register, zero for unmapped offsets
  function automatic logic [DW-1:0] reg_mask(input logic [rac_pkg::ADDR_W-1:0] addr);
    logic [DW-1:0] m;
    m = '0;
    case (addr)
      rac_pkg::OFF_ALARM_MONTH_DAY: m = rac_pkg::MASK_MONTH_DAY;
      rac_pkg::OFF_ALARM_WEEKDAY_HOURS: m = rac_pkg::MASK_WEEKDAY_HOURS;
      rac_pkg::OFF_ALARM_MINUTES_SECONDS: m = rac_pkg::MASK_MINUTES_SECONDS;
      rac_pkg::OFF_CLOCK_CONFIG_CAL: m = rac_pkg::MASK_CONFIG;
      rac_pkg::OFF_TIMER_STATUS: m = rac_pkg::MASK_STATUS;
      default: m = '0;
    endcase
    return m;
  endfunction : reg_mask

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [DW-1:0] alarm_q [NA];
  logic [DW-1:0] cfg_q;
  logic [DW-1:0] rdata_q;

  wire logic [DW-1:0] wr_mask = reg_mask(i_addr);
  wire logic [DW-1:0] wr_value = i_wdata & wr_mask;
  wire logic wren = cfg_q[rac_pkg::CFG_WREN_POS];
  wire logic timer_on = cfg_q[rac_pkg::CFG_TIMER_ON_POS];
  wire logic [rac_pkg::CAL_W-1:0] cal_byte = cfg_q[rac_pkg::CAL_LSB +: rac_pkg::CAL_W];
  wire logic cfg_hit = i_wr && (i_addr == rac_pkg::OFF_CLOCK_CONFIG_CAL);

  ////////////////////////////////////////////////////////////////////////////
  // Alarm value registers
  for (genvar g = 0; g < NA; g++) begin : g_alarm
    // Locked registers drop writes silently while write enable is clear
    wire logic hit = i_wr && (i_addr == rac_pkg::ALARM_OFF[g]);
    wire logic allowed = !rac_pkg::ALARM_LOCKED[g] || wren;
    wire logic [DW-1:0] alarm_d = wr_value & rac_pkg::ALARM_MASK[g];

    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        alarm_q[g] <= rac_pkg::RST_ALARM;
      end else if (i_ce && hit && allowed) begin
        alarm_q[g] <= alarm_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and calibration register
  // Calibration byte is written freely; timing of the write is up to software
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_q <= rac_pkg::RST_CONFIG;
    end else if (i_ce && cfg_hit) begin
      cfg_q <= wr_value & rac_pkg::MASK_CONFIG;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time base with calibration
  logic [rac_pkg::SEC_CNT_W-1:0] sec_count;

  rac_timebase #(
    .XTAL_HZ(XTAL_HZ)
  ) u_timebase (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_xtal_pin(i_xtal_pin),
    .i_timer_on(timer_on),
    .i_cal(cal_byte),
    .o_second_pulse(o_second_pulse),
    .o_minute_pulse(o_minute_pulse),
    .o_sec_count(sec_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [DW-1:0] status_word;
  logic [DW-1:0] rd_raw;

  always_comb begin
    status_word = '0;
    status_word[rac_pkg::STAT_SEC_LSB +: rac_pkg::SEC_CNT_W] = sec_count;
    status_word[rac_pkg::STAT_RUN_POS] = timer_on;
  end

  always_comb begin
    case (i_addr)
      rac_pkg::OFF_ALARM_MONTH_DAY: rd_raw = alarm_q[0];
      rac_pkg::OFF_ALARM_WEEKDAY_HOURS: rd_raw = alarm_q[1];
      rac_pkg::OFF_ALARM_MINUTES_SECONDS: rd_raw = alarm_q[2];
      rac_pkg::OFF_CLOCK_CONFIG_CAL: rd_raw = cfg_q;
      rac_pkg::OFF_TIMER_STATUS: rd_raw = status_word;
      default: rd_raw = '0;
    endcase
  end

  // Masking again keeps unused bits zero even if storage widens later
  wire logic [DW-1:0] rd_value = rd_raw & reg_mask(i_addr);
  wire logic [DW-1:0] rdata_d = i_rd ? rd_value : '0;

  // Data valid in the cycle after a strobe with i_ce high, zero otherwise; held while i_ce is low
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else if (i_ce) begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Alarm field outputs, straight from storage
  assign o_month_tens_digit = alarm_q[0][rac_pkg::MONTH_TENS_POS];
  assign o_month_ones_digit = alarm_q[0][rac_pkg::MONTH_ONES_LSB +: 4];
  assign o_day_tens_digit = alarm_q[0][rac_pkg::DAY_TENS_LSB +: 2];
  assign o_day_ones_digit = alarm_q[0][rac_pkg::DAY_ONES_LSB +: 4];
  assign o_weekday_code = alarm_q[1][rac_pkg::WEEKDAY_LSB +: 3];
  assign o_hour_tens_digit = alarm_q[1][rac_pkg::HOUR_TENS_LSB +: 2];
  assign o_hour_ones_digit = alarm_q[1][rac_pkg::HOUR_ONES_LSB +: 4];
  assign o_minute_tens_digit = alarm_q[2][rac_pkg::MIN_TENS_LSB +: 3];
  assign o_minute_ones_digit = alarm_q[2][rac_pkg::MIN_ONES_LSB +: 4];
  assign o_second_tens_digit = alarm_q[2][rac_pkg::SEC_TENS_LSB +: 3];
  assign o_second_ones_digit = alarm_q[2][rac_pkg::SEC_ONES_LSB +: 4];
  assign o_clock_write_enable = wren;

  // BCD range of digits is not checked; out-of-range values are stored as given.
  // Alarm enable lives outside this block, so false-alarm avoidance is software's job.

endmodule : rac_alarm_cal

// >>> testbench/rac_alarm_cal_monitor.sv
// Port-level checker for the alarm value and calibration block
`timescale 1ns/100ps
module rac_alarm_cal_monitor #(
  parameter int unsigned XTAL_HZ = 16
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Register port
  input wire logic i_ce,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  // Alarm digits
  input wire logic o_month_tens_digit,
  input wire logic [3:0] o_month_ones_digit,
  input wire logic [1:0] o_day_tens_digit,
  input wire logic [3:0] o_day_ones_digit,
  input wire logic [2:0] o_weekday_code,
  input wire logic [1:0] o_hour_tens_digit,
  input wire logic [3:0] o_hour_ones_digit,
  input wire logic [2:0] o_minute_tens_digit,
  input wire logic [3:0] o_minute_ones_digit,
  input wire logic [2:0] o_second_tens_digit,
  input wire logic [3:0] o_second_ones_digit,
  // Time base
  input wire logic o_clock_write_enable,
  input wire logic o_second_pulse,
  input wire logic o_minute_pulse
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  logic [15:0] wd_q;
  always_ff @(posedge i_core_clk) wd_q <= i_wdata;
  wire [15:0] md = {3'h0, o_month_tens_digit, o_month_ones_digit, 2'h0, o_day_tens_digit, o_day_ones_digit};
  wire [15:0] wh = {5'h00, o_weekday_code, 2'h0, o_hour_tens_digit, o_hour_ones_digit};
  wire [15:0] ms = {1'b0, o_minute_tens_digit, o_minute_ones_digit, 1'b0, o_second_tens_digit, o_second_ones_digit};
  sequence s_wr(logic [2:0] a);
    i_ce && i_wr && i_addr == a;
  endsequence
  sequence s_rd(logic [2:0] a);
    i_ce && i_rd && i_addr == a;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  property p_md_wr;
    s_wr(3'h0) ##0 o_clock_write_enable |=> md == (wd_q & 16'h1f3f);
  endproperty
  a_md_wr: assert property (p_md_wr) else $error("month/day write lost");
  property p_wh_wr;
    s_wr(3'h1) ##0 o_clock_write_enable |=> wh == (wd_q & 16'h073f);
  endproperty
  a_wh_wr: assert property (p_wh_wr) else $error("weekday/hours write lost");
  property p_ms_wr;
    s_wr(3'h2) |=> ms == (wd_q & 16'h7f7f);
  endproperty
  a_ms_wr: assert property (p_ms_wr) else $error("minutes/seconds write lost");
  property p_locked;
    (s_wr(3'h0) or s_wr(3'h1)) ##0 !o_clock_write_enable |=> $stable(md) && $stable(wh);
  endproperty
  a_locked: assert property (p_locked) else $error("locked alarm changed");
  property p_rd_md;
    s_rd(3'h0) |=> o_rdata == md;
  endproperty
  a_rd_md: assert property (p_rd_md) else $error("month/day readback wrong");
  property p_rd_ms;
    s_rd(3'h2) |=> o_rdata == ms;
  endproperty
  a_rd_ms: assert property (p_rd_ms) else $error("minutes/seconds readback wrong");
  property p_min_sec;
    o_minute_pulse |-> o_second_pulse;
  endproperty
  a_min_sec: assert property (p_min_sec) else $error("minute pulse without second");
  property p_sec_one;
    o_second_pulse |=> !o_second_pulse;
  endproperty
  a_sec_one: assert property (p_sec_one) else $error("second pulse too long");
endmodule : rac_alarm_cal_monitor

// >>> testbench/test_rac_alarm_cal.sv
// Self-checking bench for the alarm value and calibration block
`timescale 1ns/100ps
module test_rac_alarm_cal;
  // Short second keeps each minute near 8k cycles
  localparam int unsigned XTAL = 16;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_xtal_pin = 1'b0;
  logic [15:0] o_rdata;
  logic o_month_tens_digit, o_clock_write_enable, o_second_pulse, o_minute_pulse;
  logic [3:0] o_month_ones_digit, o_day_ones_digit, o_hour_ones_digit, o_minute_ones_digit, o_second_ones_digit;
  logic [2:0] o_weekday_code, o_minute_tens_digit, o_second_tens_digit;
  logic [1:0] o_day_tens_digit, o_hour_tens_digit;
  logic [15:0] dg [3];
  logic [15:0] mdl [3] = '{default: 16'h0000};
  logic [15:0] rv;
  int seed = 32'hca942d4a;
  int fails = 0;
  int n_checks = 0;
  bit wren = 1'b0;
  assign dg[0] = {3'h0, o_month_tens_digit, o_month_ones_digit, 2'h0, o_day_tens_digit, o_day_ones_digit};
  assign dg[1] = {5'h00, o_weekday_code, 2'h0, o_hour_tens_digit, o_hour_ones_digit};
  assign dg[2] = {1'b0, o_minute_tens_digit, o_minute_ones_digit, 1'b0, o_second_tens_digit, o_second_ones_digit};
  rac_alarm_cal #(.XTAL_HZ(XTAL)) u_dut (.*);
  initial forever #5 i_core_clk = ~i_core_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  function automatic logic [15:0] f_next(input int i, input logic [15:0] old, input logic [15:0] d, input bit we);
    if (rac_pkg::ALARM_LOCKED[i] && !we)
      return old;
    return d & rac_pkg::ALARM_MASK[i];
  endfunction : f_next
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  task automatic alarm_wr(input int i, input logic [15:0] d);
    wr(rac_pkg::ALARM_OFF[i], d);
    mdl[i] = f_next(i, mdl[i], d, wren);
  endtask : alarm_wr
  task automatic chk_alarms();
    for (int i = 0; i < 3; i++) begin
      rd(rac_pkg::ALARM_OFF[i], rv);
      chk(rv, mdl[i]);
      chk(dg[i], mdl[i]);
    end
  endtask : chk_alarms
  // One crystal edge, pin high four cycles then low four
  task automatic xedge(output logic sec, output logic mn);
    sec = 1'b0;
    mn = 1'b0;
    for (int k = 0; k < 8; k++) begin
      @(posedge i_core_clk);
      i_xtal_pin <= (k < 4);
      #1;
      sec |= o_second_pulse;
      mn |= o_minute_pulse;
    end
  endtask : xedge
  task automatic run_sec(output int len, output logic mn);
    logic s;
    len = 0;
    do begin
      xedge(s, mn);
      len++;
    end while (!s && len < 200);
    if (!s) begin
      fails++;
      test_done();
    end
  endtask : run_sec
  task automatic cal_test(input logic [7:0] cal);
    int len;
    int guard;
    int e;
    logic mn;
    wr(rac_pkg::OFF_CLOCK_CONFIG_CAL, 16'ha000 | {8'h00, cal});
    e = int'(XTAL) - 4 * int'($signed(cal));
    guard = 0;
    mn = 1'b0;
    while (!mn && guard < 70) begin
      run_sec(len, mn);
      guard++;
    end
    chk({15'h0000, mn}, 16'h0001);
    run_sec(len, mn);
    chk(16'(len), 16'(e));
    run_sec(len, mn);
    chk(16'(len), 16'(XTAL));
    $display("test done: calibration %h", cal);
  endtask : cal_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic s;
    logic mn;
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    chk_alarms();
    for (int i = 0; i < 3; i++) alarm_wr(i, 16'hffff);
    chk_alarms();
    @(posedge i_core_clk);
    i_ce <= 1'b0;
    wr(3'h2, 16'h5a5a);
    @(posedge i_core_clk);
    i_ce <= 1'b1;
    chk_alarms();
    $display("test done: locked and frozen");
    wr(rac_pkg::OFF_CLOCK_CONFIG_CAL, 16'h2000);
    wren = 1'b1;
    rd(rac_pkg::OFF_CLOCK_CONFIG_CAL, rv);
    chk(rv, 16'h2000);
    chk({15'h0000, o_clock_write_enable}, 16'h0001);
    alarm_wr(0, 16'h1239);
    alarm_wr(1, 16'h0623);
    alarm_wr(2, 16'h5959);
    chk_alarms();
    for (int n = 0; n < 20; n++) begin
      alarm_wr($unsigned($random(seed)) % 3, 16'($random(seed)));
      chk_alarms();
    end
    wr(3'h5, 16'hffff);
    rd(3'h5, rv);
    chk(rv, 16'h0000);
    wr(rac_pkg::OFF_CLOCK_CONFIG_CAL, 16'h0000);
    wren = 1'b0;
    alarm_wr(0, 16'($random(seed)));
    alarm_wr(1, 16'($random(seed)));
    chk_alarms();
    $display("test done: registers");
    // Timer off: crystal edges must not advance anything
    for (int n = 0; n < 20; n++) begin
      xedge(s, mn);
      chk({15'h0000, s}, 16'h0000);
    end
    // Fast crystal needs negative units, slow crystal positive
    cal_test(8'hfe);
    cal_test(8'h02);
    // Status is read-only: two seconds past the last minute, timer running
    wr(rac_pkg::OFF_TIMER_STATUS, 16'hffff);
    rd(rac_pkg::OFF_TIMER_STATUS, rv);
    chk(rv, 16'h8002);
    $display("test done: status");
    test_done();
  end
endmodule : test_rac_alarm_cal
bind rac_alarm_cal rac_alarm_cal_monitor #(.XTAL_HZ(XTAL_HZ)) u_mon (.*);
